// ### hdl/cmadr_pkg.sv
// Package of constants and carriers for the core memory addressing block
package cmadr_pkg;

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam int          CMADR_PROG_SPACE   = 65536;
    localparam int          CMADR_PROG_DEFAULT = 8192;
    localparam int          CMADR_PROG_MID     = 4096;
    localparam int          CMADR_PROG_SMALL   = 2048;
    localparam logic [15:0] CMADR_FACTORY_BASE = 16'h1e00;
    localparam int          CMADR_RAM_BYTES    = 256;
    localparam logic [7:0]  CMADR_UPPER_BASE   = 8'h80;
    localparam logic [7:0]  CMADR_BIT_BYTE_LO  = 8'h20;
    localparam logic [7:0]  CMADR_BIT_SFR_BASE = 8'h80;

    // ------------------------------------------------------------
    // Special function register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CMADR_SFR_STACK_TOP   = 8'h81;
    localparam logic [7:0]  CMADR_SFR_STATUS_WORD = 8'hd0;
    localparam logic [7:0]  CMADR_SFR_STORE_CTL   = 8'h8f;
    localparam logic [7:0]  CMADR_STACK_RESET     = 8'h07;
    localparam logic [7:0]  CMADR_STATUS_RESET    = 8'h00;
    localparam logic [7:0]  CMADR_STORE_RESET     = 8'h00;
    localparam int          CMADR_BANK_LSB        = 3;
    localparam int          CMADR_STORE_WEN_BIT   = 0;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMADR_OP_NOP_ALT = 8'ha5;
    localparam logic [7:0]  CMADR_OP_NOP     = 8'h00;

    // ------------------------------------------------------------
    // Operation kinds
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMADR_OP_IDLE     = 4'h0,
        CMADR_OP_DIRECT   = 4'h1,
        CMADR_OP_INDEXED  = 4'h2,
        CMADR_OP_BANKREG  = 4'h3,
        CMADR_OP_BIT      = 4'h4,
        CMADR_OP_PUSH     = 4'h5,
        CMADR_OP_POP      = 4'h6,
        CMADR_OP_REL      = 4'h7,
        CMADR_OP_PAGE     = 4'h8,
        CMADR_OP_FULL     = 4'h9,
        CMADR_OP_EXT_MOVE = 4'ha,
        CMADR_OP_CODE     = 4'hb
    } cmadr_op_t;

    typedef struct packed {
        cmadr_op_t   op;
        logic        wr;
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic [15:0] next_pc;
        logic [15:0] target;
        logic [7:0]  opcode;
    } cmadr_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  rdata;
        logic        bit_val;
        logic [15:0] branch_pc;
        logic        prog_wr;
        logic [15:0] prog_addr;
        logic        fault;
    } cmadr_rsp_t;

endpackage

// ### hdl/cmadr_core.sv
// Memory addressing, data RAM, stack pointer and status word of the core
`timescale 1ns/10ps
// Notes on behaviour
// - Relative branch adds signed 8-bit displacement to next-instruction address.
// - Direct addresses 0x00-0x7F hit RAM, 0x80-0xFF hit special registers.
// - Short forms replace low 11 bits of next address, staying in page.
// - Long forms use the full 16-bit target anywhere in program memory.
// - Opcode 0xA5 behaves as no operation, with no side effects.
// - Program addresses decode across a 64k-byte space.
// - Largest variant program store spans 0x0000 through 0x1FFF contiguously.
// - Program store size is a parameter: 8192, 4096 or 2048 bytes.
// - Program writes happen only by external move with store write enable set.
// - RAM holds 256 bytes; lower 128 reachable directly and indirectly.
// - Above 0x7F indirect hits upper RAM, direct hits special registers.
// - Bytes 0x00-0x1F are four eight-register banks chosen by status bits 3,4.
// - Indexed operands use only registers 0 and 1 of the active bank.
// - Bytes 0x20-0x2F give 128 bits, bit address 8*(byte-0x20)+position.
// - Bit versus byte access depends only on the operation kind.
// - Push writes at pointer plus one, then increments the pointer.
// - Reset loads the stack pointer with 0x07; first push lands at 0x08.
// - Stack may live anywhere in 256-byte RAM, reached indirectly.
// - Special registers at addresses ending 0x0 or 0x8 are bit addressable.
module cmadr_core
    import cmadr_pkg::*;
#(
    parameter int PROG_BYTES = CMADR_PROG_DEFAULT
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_CE,
    input  wire cmadr_req_t  I_REQ,
    input  wire logic        I_REQ_VALID,
    output cmadr_rsp_t       O_RSP,
    output logic [7:0]       O_STACK_TOP,
    output logic [1:0]       O_BANK
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (PROG_BYTES != CMADR_PROG_DEFAULT && PROG_BYTES != CMADR_PROG_MID &&
        PROG_BYTES != CMADR_PROG_SMALL) begin : g_bad_prog_bytes
        $error("PROG_BYTES must be 8192, 4096 or 2048");
    end

    localparam logic [16:0] PROG_LIMIT = 17'(PROG_BYTES);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] ram_reg [CMADR_RAM_BYTES];
    logic [7:0] stack_top_pointer_reg;
    logic [7:0] program_status_word_reg;
    logic [7:0] program_store_control_reg;

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic logic is_sfr_direct(input logic [7:0] a);
        return a >= CMADR_UPPER_BASE;
    endfunction

    function automatic logic [7:0] bank_reg_addr(input logic [1:0] bank,
                                                 input logic [2:0] idx);
        return {3'h0, bank, idx};
    endfunction

    // Bit address to byte address; position is the low three address bits
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        if (b < CMADR_UPPER_BASE) begin
            return CMADR_BIT_BYTE_LO + {4'h0, b[6:3]};
        end
        return {b[7:3], 3'h0};
    endfunction

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    logic op_bit;
    logic op_push;
    logic op_pop;
    logic op_ext_move;
    logic op_code;

    assign op_bit      = (I_REQ.op == CMADR_OP_BIT);
    assign op_push     = (I_REQ.op == CMADR_OP_PUSH);
    assign op_pop      = (I_REQ.op == CMADR_OP_POP);
    assign op_ext_move = (I_REQ.op == CMADR_OP_EXT_MOVE);
    assign op_code     = (I_REQ.op == CMADR_OP_CODE);

    // ------------------------------------------------------------
    // Combinational address resolution
    // ------------------------------------------------------------
    logic [1:0] bank;
    logic [7:0] index_val;
    logic [7:0] eff_addr;
    logic       eff_sfr;
    logic       is_nop;

    assign bank = program_status_word_reg[CMADR_BANK_LSB +: 2];
    assign index_val = ram_reg[bank_reg_addr(bank, {2'h0, I_REQ.addr[0]})];
    assign is_nop = (I_REQ.opcode == CMADR_OP_NOP_ALT) ||
                    (I_REQ.opcode == CMADR_OP_NOP);

    always_comb begin
        eff_addr = I_REQ.addr;
        eff_sfr  = 1'b0;
        unique case (I_REQ.op)
            CMADR_OP_DIRECT: begin
                eff_sfr = is_sfr_direct(I_REQ.addr);
            end
            CMADR_OP_INDEXED: begin
                eff_addr = index_val;
            end
            CMADR_OP_BANKREG: begin
                eff_addr = bank_reg_addr(bank, I_REQ.addr[2:0]);
            end
            CMADR_OP_BIT: begin
                eff_addr = bit_byte(I_REQ.addr);
                eff_sfr  = is_sfr_direct(I_REQ.addr);
            end
            CMADR_OP_PUSH: begin
                eff_addr = stack_top_pointer_reg + 8'h01;
            end
            CMADR_OP_POP: begin
                eff_addr = stack_top_pointer_reg;
            end
            default: begin
                eff_addr = I_REQ.addr;
            end
        endcase
    end

    // Special register read mux
    logic [7:0] sfr_rdata;
    always_comb begin
        unique case (eff_addr)
            CMADR_SFR_STACK_TOP:   sfr_rdata = stack_top_pointer_reg;
            CMADR_SFR_STATUS_WORD: sfr_rdata = program_status_word_reg;
            CMADR_SFR_STORE_CTL:   sfr_rdata = program_store_control_reg;
            default:               sfr_rdata = 8'h00;
        endcase
    end

    logic [7:0] rd_byte;
    logic       bit_ok;
    logic       do_op;
    assign rd_byte = eff_sfr ? sfr_rdata : ram_reg[eff_addr];
    assign bit_ok  = !is_sfr_direct(I_REQ.addr) ||
                     ((bit_byte(I_REQ.addr) & 8'h07) == 8'h00);
    assign do_op   = I_CE && I_REQ_VALID && !is_nop;

    // Bit write value merged into the byte
    logic [7:0] bit_merged;
    for (genvar gi = 0; gi < 8; gi++) begin : g_bit_lane
        assign bit_merged[gi] = (I_REQ.addr[2:0] == 3'(gi)) ? I_REQ.wdata[0]
                                                            : rd_byte[gi];
    end

    logic       wr_en;
    logic [7:0] wr_val;
    always_comb begin
        wr_en  = 1'b0;
        wr_val = I_REQ.wdata;
        unique case (I_REQ.op)
            CMADR_OP_DIRECT, CMADR_OP_INDEXED, CMADR_OP_BANKREG: begin
                wr_en = I_REQ.wr;
            end
            CMADR_OP_BIT: begin
                wr_en  = I_REQ.wr && bit_ok;
                wr_val = bit_merged;
            end
            CMADR_OP_PUSH: begin
                wr_en = 1'b1;
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    logic ram_wr;
    logic spec_wr;
    logic stack_wr;
    logic status_wr;
    logic store_wr;

    assign ram_wr    = do_op && wr_en && !eff_sfr;
    assign spec_wr   = do_op && wr_en && eff_sfr;
    assign stack_wr  = spec_wr && (eff_addr == CMADR_SFR_STACK_TOP);
    assign status_wr = spec_wr && (eff_addr == CMADR_SFR_STATUS_WORD);
    assign store_wr  = spec_wr && (eff_addr == CMADR_SFR_STORE_CTL);

    // ------------------------------------------------------------
    // Data RAM
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (ram_wr) begin
            ram_reg[eff_addr] <= wr_val;
        end
    end

    // ------------------------------------------------------------
    // Stack pointer
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            stack_top_pointer_reg <= CMADR_STACK_RESET;
        end else if (do_op) begin
            if (op_push) begin
                stack_top_pointer_reg <= stack_top_pointer_reg + 8'h01;
            end else if (op_pop) begin
                stack_top_pointer_reg <= stack_top_pointer_reg - 8'h01;
            end else if (stack_wr) begin
                stack_top_pointer_reg <= wr_val;
            end
        end
    end

    // ------------------------------------------------------------
    // Status word and store control
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            program_status_word_reg <= CMADR_STATUS_RESET;
        end else if (status_wr) begin
            program_status_word_reg <= wr_val;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            program_store_control_reg <= CMADR_STORE_RESET;
        end else if (store_wr) begin
            program_store_control_reg <= wr_val;
        end
    end

    // ------------------------------------------------------------
    // Branch and program address
    // ------------------------------------------------------------
    logic [15:0] branch_pc;
    logic [15:0] rel_ext;
    assign rel_ext = {{8{I_REQ.addr[7]}}, I_REQ.addr};
    always_comb begin
        unique case (I_REQ.op)
            CMADR_OP_REL:  branch_pc = I_REQ.next_pc + rel_ext;
            CMADR_OP_PAGE: branch_pc = {I_REQ.next_pc[15:11], I_REQ.target[10:0]};
            CMADR_OP_FULL: branch_pc = I_REQ.target;
            default:       branch_pc = I_REQ.next_pc;
        endcase
    end

    logic prog_in_range;
    logic prog_wr;
    logic bit_fault;
    logic range_fault;
    assign prog_in_range = {1'b0, I_REQ.target} < PROG_LIMIT;
    assign prog_wr       = op_ext_move && I_REQ.wr &&
                           program_store_control_reg[CMADR_STORE_WEN_BIT] &&
                           prog_in_range;
    assign bit_fault     = op_bit && !bit_ok;
    assign range_fault   = (op_ext_move || op_code) && !prog_in_range;

    // ------------------------------------------------------------
    // Response valid
    // ------------------------------------------------------------
    logic rsp_valid_reg;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rsp_valid_reg <= 1'b0;
        end else if (I_CE) begin
            rsp_valid_reg <= I_REQ_VALID;
        end
    end

    // ------------------------------------------------------------
    // Response data
    // ------------------------------------------------------------
    logic [7:0] rsp_rdata_reg;
    logic       rsp_bit_reg;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rsp_rdata_reg <= 8'h00;
            rsp_bit_reg   <= 1'b0;
        end else if (I_CE) begin
            rsp_rdata_reg <= do_op ? rd_byte : 8'h00;
            rsp_bit_reg   <= do_op && rd_byte[I_REQ.addr[2:0]];
        end
    end

    // ------------------------------------------------------------
    // Branch target
    // ------------------------------------------------------------
    logic [15:0] rsp_branch_reg;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rsp_branch_reg <= 16'h0000;
        end else if (I_CE) begin
            rsp_branch_reg <= branch_pc;
        end
    end

    // ------------------------------------------------------------
    // Program store write
    // ------------------------------------------------------------
    logic        rsp_prog_wr_reg;
    logic [15:0] rsp_prog_addr_reg;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rsp_prog_wr_reg   <= 1'b0;
            rsp_prog_addr_reg <= 16'h0000;
        end else if (I_CE) begin
            rsp_prog_wr_reg   <= do_op && prog_wr;
            rsp_prog_addr_reg <= I_REQ.target;
        end
    end

    // ------------------------------------------------------------
    // Fault
    // ------------------------------------------------------------
    logic rsp_fault_reg;
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rsp_fault_reg <= 1'b0;
        end else if (I_CE) begin
            rsp_fault_reg <= do_op && (bit_fault || range_fault);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_RSP       = '{valid:     rsp_valid_reg,
                           rdata:     rsp_rdata_reg,
                           bit_val:   rsp_bit_reg,
                           branch_pc: rsp_branch_reg,
                           prog_wr:   rsp_prog_wr_reg,
                           prog_addr: rsp_prog_addr_reg,
                           fault:     rsp_fault_reg};
    assign O_STACK_TOP = stack_top_pointer_reg;
    assign O_BANK      = program_status_word_reg[CMADR_BANK_LSB +: 2];

endmodule // cmadr_core

// ### verif/cmadr_core_monitor.sv
// Port checker for the core memory addressing block
`timescale 1ns/10ps
module cmadr_core_monitor
    import cmadr_pkg::*;
#(
    parameter int PROG_BYTES = CMADR_PROG_DEFAULT
) (
    input  wire logic       I_CLK,
    input  wire logic       I_RSTN,
    input  wire logic       I_CE,
    input  wire cmadr_req_t I_REQ,
    input  wire logic       I_REQ_VALID,
    input  wire cmadr_rsp_t O_RSP,
    input  wire logic [7:0] O_STACK_TOP,
    input  wire logic [1:0] O_BANK
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    logic go;
    logic no_operation;
    assign no_operation = I_REQ.opcode == CMADR_OP_NOP || I_REQ.opcode == CMADR_OP_NOP_ALT;
    assign go  = I_CE && I_REQ_VALID && !no_operation;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    property p_sp_rst; $rose(I_RSTN) |-> O_STACK_TOP == CMADR_STACK_RESET; endproperty
    a_sp_rst: assert property (p_sp_rst) else $error("stack reset value wrong");
    property p_push;
        go && I_REQ.op == CMADR_OP_PUSH |=> O_STACK_TOP == $past(O_STACK_TOP) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push pointer step wrong");
    property p_pop;
        go && I_REQ.op == CMADR_OP_POP |=> O_STACK_TOP == $past(O_STACK_TOP) - 8'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop pointer step wrong");
    property p_nop;
        I_CE && I_REQ_VALID && no_operation |=> $stable(O_STACK_TOP) && $stable(O_BANK)
            && O_RSP.rdata == 8'h00 && !O_RSP.prog_wr;
    endproperty
    a_nop: assert property (p_nop) else $error("no-operation had an effect");
    property p_rel;
        go && I_REQ.op == CMADR_OP_REL |=> O_RSP.branch_pc == $past(I_REQ.next_pc)
            + {{8{$past(I_REQ.addr[7])}}, $past(I_REQ.addr)};
    endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_page;
        go && I_REQ.op == CMADR_OP_PAGE |=> O_RSP.branch_pc
            == {$past(I_REQ.next_pc[15:11]), $past(I_REQ.target[10:0])};
    endproperty
    a_page: assert property (p_page) else $error("page target wrong");
    property p_full;
        go && I_REQ.op == CMADR_OP_FULL |=> O_RSP.branch_pc == $past(I_REQ.target);
    endproperty
    a_full: assert property (p_full) else $error("full target wrong");
    property p_bank;
        go && I_REQ.op == CMADR_OP_DIRECT && I_REQ.wr && I_REQ.addr == CMADR_SFR_STATUS_WORD
            |=> O_BANK == $past(I_REQ.wdata[4:3]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");
    property p_sp_rd;
        go && I_REQ.op == CMADR_OP_DIRECT && !I_REQ.wr && I_REQ.addr == CMADR_SFR_STACK_TOP
            |=> O_RSP.rdata == $past(O_STACK_TOP);
    endproperty
    a_sp_rd: assert property (p_sp_rd) else $error("direct pointer read wrong");
    property p_prog;
        go && I_REQ.op == CMADR_OP_EXT_MOVE && I_REQ.wr && I_REQ.target >= PROG_BYTES
            |=> O_RSP.fault && !O_RSP.prog_wr;
    endproperty
    a_prog: assert property (p_prog) else $error("store write past end");
    property p_prog_addr;
        go && I_REQ.op == CMADR_OP_EXT_MOVE |=> O_RSP.prog_addr == $past(I_REQ.target);
    endproperty
    a_prog_addr: assert property (p_prog_addr) else $error("store address wrong");
    c_push: cover property (go && I_REQ.op == CMADR_OP_PUSH);
    c_prog: cover property (O_RSP.prog_wr);
    c_rel: cover property (go && I_REQ.op == CMADR_OP_REL);
endmodule // cmadr_core_monitor

bind cmadr_core cmadr_core_monitor #(.PROG_BYTES(PROG_BYTES)) u_cmadr_core_monitor (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_REQ(I_REQ), .I_REQ_VALID(I_REQ_VALID),
    .O_RSP(O_RSP), .O_STACK_TOP(O_STACK_TOP), .O_BANK(O_BANK));

// ### verif/tb_cmadr_core.sv
// Self-checking testbench of the core memory addressing block
`timescale 1ns/10ps
module tb_cmadr_core;
    import cmadr_pkg::*;
    typedef struct {int k; logic [15:0] e;} cmadr_exp_t;
    logic        I_CLK       = 1'b0;
    logic        I_RSTN      = 1'b0;
    logic        I_CE        = 1'b1;
    logic        ce_q        = 1'b1;
    logic        I_REQ_VALID = 1'b0;
    cmadr_req_t  I_REQ       = '0;
    cmadr_rsp_t  O_RSP;
    logic [7:0]  O_STACK_TOP;
    logic [1:0]  O_BANK;
    cmadr_exp_t  exp_q[$];
    cmadr_exp_t  x;
    int          err_total = 0;
    int          cmp_count = 0;
    logic [7:0]  v, p, oc = 8'h01;
    logic [15:0] n = '0, t = '0, g;
    string       nm[7] = '{"ack", "rdata", "branch_pc", "prog_flags", "bit_val", "stack", "bank"};
    // ------------------------------------------------------------
    // Clock, design and tasks
    // ------------------------------------------------------------
    always #5 I_CLK = ~I_CLK;
    always @(posedge I_CLK) begin
        ce_q <= I_CE;
    end
    cmadr_core #(.PROG_BYTES(CMADR_PROG_DEFAULT)) u_cmadr_core (
        .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_REQ(I_REQ), .I_REQ_VALID(I_REQ_VALID),
        .O_RSP(O_RSP), .O_STACK_TOP(O_STACK_TOP), .O_BANK(O_BANK));
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input int k, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm[k], e, s);
        end
    endtask
    task automatic rq(input cmadr_op_t op, input logic wr, input logic [7:0] a,
                      input logic [7:0] d, input int k, input logic [15:0] e);
        @(posedge I_CLK);
        I_REQ <= '{op: op, wr: wr, addr: a, wdata: d, next_pc: n, target: t, opcode: oc};
        I_REQ_VALID <= 1'b1;
        exp_q.push_back('{k, e});
    endtask
    task automatic idle();
        @(posedge I_CLK);
        I_REQ_VALID <= 1'b0;
        repeat (3) @(negedge I_CLK);
    endtask
    always @(negedge I_CLK) begin
        if (O_RSP.valid === 1'b1 && ce_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(0, 16'h0000, 16'h0001);
            end else begin
                x = exp_q.pop_front();
                g = (x.k == 1) ? {8'h00, O_RSP.rdata} : (x.k == 2) ? O_RSP.branch_pc :
                    (x.k == 3) ? {14'h0, O_RSP.fault, O_RSP.prog_wr} :
                    (x.k == 4) ? {15'h0, O_RSP.bit_val} : x.e;
                chk(x.k, x.e, g);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge I_CLK);
        err_total++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'habc6));
        repeat (6) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        @(negedge I_CLK);
        chk(5, 16'h0007, {8'h00, O_STACK_TOP});
        v = 8'($urandom);
        rq(CMADR_OP_PUSH, 1, 8'h00, v, 0, 0);
        rq(CMADR_OP_DIRECT, 0, 8'h08, 0, 1, {8'h00, v});
        rq(CMADR_OP_DIRECT, 0, 8'h81, 0, 1, 16'h0008);
        rq(CMADR_OP_POP, 0, 8'h00, 0, 1, {8'h00, v});
        oc = 8'ha5;
        rq(CMADR_OP_PUSH, 1, 8'h00, v, 1, 0);
        oc = 8'h00;
        rq(CMADR_OP_PUSH, 1, 8'h00, v, 1, 0);
        oc = 8'h01;
        rq(CMADR_OP_DIRECT, 0, 8'h81, 0, 1, 16'h0007);
        for (int b = 0; b < 4; b++) begin
            p = 8'h90 | (8'($urandom) & 8'h0f);
            v = 8'($urandom);
            rq(CMADR_OP_DIRECT, 1, CMADR_SFR_STATUS_WORD, 8'(b << 3), 0, 0);
            rq(CMADR_OP_BANKREG, 1, 8'h01, p, 0, 0);
            rq(CMADR_OP_DIRECT, 0, 8'(b * 8 + 1), 0, 1, {8'h00, p});
            rq(CMADR_OP_INDEXED, 1, 8'h01, v, 0, 0);
            rq(CMADR_OP_DIRECT, 1, p, ~v, 0, 0);
            rq(CMADR_OP_INDEXED, 0, 8'h01, 0, 1, {8'h00, v});
            rq(CMADR_OP_DIRECT, 0, p, 0, 1, 16'h0000);
        end
        rq(CMADR_OP_BANKREG, 1, 8'h00, 8'h40, 0, 0);
        rq(CMADR_OP_INDEXED, 1, 8'h00, 8'h6d, 0, 0);
        rq(CMADR_OP_DIRECT, 0, 8'h40, 0, 1, 16'h006d);
        rq(CMADR_OP_DIRECT, 1, CMADR_SFR_STATUS_WORD, 8'h00, 0, 0);
        v = 8'($urandom) & 8'h7f;
        rq(CMADR_OP_DIRECT, 1, 8'h20 | {4'h0, v[6:3]}, 8'h00, 0, 0);
        rq(CMADR_OP_BIT, 1, v, 8'h01, 0, 0);
        rq(CMADR_OP_DIRECT, 0, 8'h20 | {4'h0, v[6:3]}, 0, 1, 16'h1 << v[2:0]);
        rq(CMADR_OP_BIT, 0, v, 0, 4, 16'h0001);
        rq(CMADR_OP_BIT, 1, 8'hd4, 8'h01, 0, 0);
        rq(CMADR_OP_DIRECT, 0, CMADR_SFR_STATUS_WORD, 0, 1, 16'h0010);
        idle();
        chk(6, 16'h0002, {14'h0, O_BANK});
        rq(CMADR_OP_DIRECT, 1, 8'h81, 8'hfe, 0, 0);
        rq(CMADR_OP_PUSH, 1, 8'h00, 8'h3c, 0, 0);
        rq(CMADR_OP_PUSH, 1, 8'h00, 8'hc3, 0, 0);
        rq(CMADR_OP_DIRECT, 0, 8'h81, 0, 1, 16'h0000);
        rq(CMADR_OP_POP, 0, 8'h00, 0, 1, 16'h00c3);
        rq(CMADR_OP_POP, 0, 8'h00, 0, 1, 16'h003c);
        @(posedge I_CLK);
        I_CE <= 1'b0;
        I_REQ <= '{op: CMADR_OP_PUSH, wr: 1'b1, addr: 8'h00, wdata: 8'h99, next_pc: n,
                   target: t, opcode: oc};
        I_REQ_VALID <= 1'b1;
        repeat (3) @(posedge I_CLK);
        I_REQ_VALID <= 1'b0;
        I_CE <= 1'b1;
        @(negedge I_CLK);
        chk(5, 16'h00fe, {8'h00, O_STACK_TOP});
        for (int i = 0; i < 4; i++) begin
            n = 16'($urandom);
            t = 16'($urandom);
            v = 8'($urandom);
            rq(CMADR_OP_REL, 0, v, 0, 2, n + {{8{v[7]}}, v});
            rq(CMADR_OP_PAGE, 0, 8'h00, 0, 2, {n[15:11], t[10:0]});
            rq(CMADR_OP_FULL, 0, 8'h00, 0, 2, t);
        end
        t = 16'h0100;
        rq(CMADR_OP_EXT_MOVE, 1, 8'h00, 8'h5a, 3, 16'h0000);
        rq(CMADR_OP_DIRECT, 1, CMADR_SFR_STORE_CTL, 8'h01, 0, 0);
        rq(CMADR_OP_EXT_MOVE, 1, 8'h00, 8'h5a, 3, 16'h0001);
        t = 16'h1dff;
        rq(CMADR_OP_EXT_MOVE, 1, 8'h00, 8'ha5, 3, 16'h0001);
        t = 16'h2000;
        rq(CMADR_OP_EXT_MOVE, 1, 8'h00, 8'ha5, 3, 16'h0002);
        rq(CMADR_OP_CODE, 0, 8'h00, 0, 3, 16'h0002);
        idle();
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge I_CLK);
        if (exp_q.size() > 0) err_total++;
        give_verdict();
    end
endmodule // tb_cmadr_core
